// file: rtl/dtc_top.sv
/*
 * dtc_top: two 16-bit timer/counters behind an APB slave.
 * Assumes pclk at 250 MHz, asynchronous active-low presetn, pins that
 * arrive asynchronously, and an interrupt controller on pclk that pulses
 * irq_ack when it services an overflow request.
 */
// Implementation choices: the register addresses and the APB interface to the registers.
//
// Contract
// - while running, input bumps low byte; low carry bumps high; high carry sets flag.
// - setting run keeps the count; counting resumes from held value.
// - source zero counts once per peripheral cycle.
// - source one counts a high sample followed by a low sample.
// - edge count lands in the cycle after detection, two peripheral cycles per count.
// - without gating run alone enables; with gating the gate pin also decides; timer 1 ignores run1 while timer 0 is in mode 3.
// - gated timer counts only while gate pin high and run set; timer 1 needs no run1 while timer 0 is in mode 3.
// - rollover from all ones sets overflow flag and raises request.
// - mode 0 13-bit, 1 16-bit, 2 auto-reload, 3 split or halt.
// - mode 0: high byte fed by five-bit prescaler in low byte.
// - mode 1: cascaded 16-bit counter, input increments low byte.
// - mode 2: low byte overflow sets flag and reloads from unchanged high byte.
// - new reload value may be written any time, used at next overflow.
// - servicing the request clears the overflow flag.
// - software may clear timer 0 flag while its interrupt is disabled.
// - timer 0 mode 3: low byte uses timer 0 controls; high uses only run1 and counts once per peripheral cycle, ignoring timer 1's gate and source.
// - timer 1 mode 3 halts and holds; leaving it resumes counting.
`timescale 1ns/1ps
module dtc_top
   import dtc_pkg::*;
#(
   parameter int PERIPH_DIV = DTC_PERIPH_DIV
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [DTC_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // external pins
   input  wire logic              count_pin_0,
   input  wire logic              count_pin_1,
   input  wire logic              gate_pin_0,
   input  wire logic              gate_pin_1,
   // interrupt controller
   input  wire logic [1:0]        irq_ack,
   input  wire logic              t0_irq_enabled,
   output logic      [1:0]        overflow_flag
);

   logic [7:0]  div_cnt_r;
   logic        per_tick_r;
   logic [3:0]  sync1_r;
   logic [3:0]  sync2_r;
   logic [1:0]  ev_smp_r;
   logic        run0_r;
   logic        run1_r;
   logic        flag0_r;
   logic        flag1_r;
   logic [7:0]  mode_r;
   logic [7:0]  lo0_r;
   logic [7:0]  hi0_r;
   logic [7:0]  lo1_r;
   logic [7:0]  hi1_r;
   logic        pready_r;
   logic        pslverr_r;
   logic [31:0] prdata_r;

   // peripheral cycle enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_r  <= 8'h00;
         per_tick_r <= 1'b0;
      end else begin
         div_cnt_r  <= (div_cnt_r == 8'(PERIPH_DIV - 1)) ? 8'h00 : div_cnt_r + 8'h01;
         per_tick_r <= (div_cnt_r == 8'(PERIPH_DIV - 1));
      end
   end

   // pin synchronisers: {gate_pin_1, gate_pin_0, count1, count0}
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
      end else begin
         sync1_r <= {gate_pin_1, gate_pin_0, count_pin_1, count_pin_0};
         sync2_r <= sync1_r;
      end
   end

   // event pin sampled once per peripheral cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_smp_r <= 2'h0;
      end else if (per_tick_r) begin
         ev_smp_r <= sync2_r[1:0];
      end
   end

   dtc_tmode_t tm [2];
   logic [1:0] gate_ok;
   logic [1:0] src_tick;

   assign tm[0] = dtc_tmode_t'(mode_r[DTC_TM0_LSB +: 4]);
   assign tm[1] = dtc_tmode_t'(mode_r[DTC_TM1_LSB +: 4]);

   for (genvar i = 0; i < 2; i++) begin : g_src
      assign gate_ok[i]  = ~tm[i].gate | sync2_r[2+i];
      assign src_tick[i] = per_tick_r & (tm[i].src ? (ev_smp_r[i] & ~sync2_r[i])
                                                   : 1'b1);
   end

   // one counting step of a timer in its selected mode
   function automatic dtc_cnt_t dtc_step(dtc_mode_t m, logic go, logic [7:0] hi, logic [7:0] lo);
      dtc_cnt_t r;
      r = {1'b0, hi, lo};
      if (go) begin
         case (m)
            DTC_MODE_13BIT: begin
               r.lo[4:0] = lo[4:0] + 5'h01;
               if (lo[4:0] == DTC_PRESC_MAX) begin
                  r.hi  = hi + 8'h01;
                  r.ovf = (hi == DTC_BYTE_MAX);
               end
            end
            DTC_MODE_16BIT: begin
               r = {1'b0, hi, lo} + 17'h00001;
            end
            DTC_MODE_RELOAD: begin
               if (lo == DTC_BYTE_MAX) begin
                  r.lo  = hi;
                  r.ovf = 1'b1;
               end else begin
                  r.lo = lo + 8'h01;
               end
            end
            default: begin
               {r.ovf, r.lo} = {1'b0, lo} + 9'h001;
            end
         endcase
      end
      return r;
   endfunction

   // enables and next counts
   logic       t0_split;
   logic       go0;
   logic       go0h;
   logic       go1;
   dtc_cnt_t   step0;
   dtc_cnt_t   step1;
   logic [8:0] split_hi;
   logic [7:0] hi0_calc;
   logic       set0;
   logic       set1;

   assign t0_split = (tm[0].mode == DTC_MODE_SPLIT);
   assign go0      = run0_r & gate_ok[0] & src_tick[0];
   assign go0h     = t0_split & run1_r & per_tick_r;
   assign go1      = (t0_split | run1_r) & gate_ok[1] & src_tick[1]
                     & (tm[1].mode != DTC_MODE_SPLIT);
   assign step0    = dtc_step(tm[0].mode, go0, hi0_r, lo0_r);
   assign step1    = dtc_step(tm[1].mode, go1, hi1_r, lo1_r);
   assign split_hi = {1'b0, hi0_r} + 9'h001;
   assign hi0_calc = t0_split ? (go0h ? split_hi[7:0] : hi0_r) : step0.hi;
   assign set0     = step0.ovf;
   assign set1     = t0_split ? (go0h & split_hi[8]) : step1.ovf;

   // apb decode
   logic        acc;
   logic        wr_en;
   logic        sel_ctrl;
   logic        sel_mode;
   logic        sel_t0lo;
   logic        sel_t0hi;
   logic        sel_t1lo;
   logic        sel_t1hi;
   logic        mapped;
   logic [3:0]  ctrl_word;
   logic [31:0] rd_data;

   assign acc      = psel & penable;
   assign wr_en    = acc & pready_r & pwrite;
   assign sel_ctrl = (paddr == DTC_CTRL_OFS);
   assign sel_mode = (paddr == DTC_MODE_OFS);
   assign sel_t0lo = (paddr == DTC_T0LO_OFS);
   assign sel_t0hi = (paddr == DTC_T0HI_OFS);
   assign sel_t1lo = (paddr == DTC_T1LO_OFS);
   assign sel_t1hi = (paddr == DTC_T1HI_OFS);
   assign mapped   = sel_ctrl | sel_mode | sel_t0lo | sel_t0hi | sel_t1lo | sel_t1hi;

   assign ctrl_word[DTC_RUN0_BIT]  = run0_r;
   assign ctrl_word[DTC_FLAG0_BIT] = flag0_r;
   assign ctrl_word[DTC_RUN1_BIT]  = run1_r;
   assign ctrl_word[DTC_FLAG1_BIT] = flag1_r;

   assign rd_data = sel_ctrl ? {28'h0000000, ctrl_word} :
                    sel_mode ? {24'h000000, mode_r} :
                    sel_t0lo ? {24'h000000, lo0_r} :
                    sel_t0hi ? {24'h000000, hi0_r} :
                    sel_t1lo ? {24'h000000, lo1_r} :
                    sel_t1hi ? {24'h000000, hi1_r} : 32'h00000000;

   // flag next values: hardware set wins over any clear
   logic sw_flag0;
   logic flag0_nxt;
   logic flag1_nxt;

   assign sw_flag0  = wr_en & sel_ctrl & ~t0_irq_enabled;
   assign flag0_nxt = set0 | (sw_flag0 ? pwdata[DTC_FLAG0_BIT]
                                       : (flag0_r & ~irq_ack[0]));
   assign flag1_nxt = set1 | (flag1_r & ~irq_ack[1]);

   // apb handshake: one wait state, then ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end else begin
         pready_r  <= acc & ~pready_r;
         pslverr_r <= acc & ~pready_r & ~mapped;
         if (acc & ~pready_r & ~pwrite) begin
            prdata_r <= rd_data;
         end
      end
   end

   // control, mode and flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run0_r  <= 1'b0;
         run1_r  <= 1'b0;
         flag0_r <= 1'b0;
         flag1_r <= 1'b0;
         mode_r  <= DTC_MODE_RST;
      end else begin
         flag0_r <= flag0_nxt;
         flag1_r <= flag1_nxt;
         if (wr_en & sel_ctrl) begin
            run0_r <= pwdata[DTC_RUN0_BIT];
            run1_r <= pwdata[DTC_RUN1_BIT];
         end
         if (wr_en & sel_mode) begin
            mode_r <= pwdata[7:0];
         end
      end
   end

   // count bytes: a software preset overrides the step of that byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lo0_r <= DTC_CNT_RST;
         hi0_r <= DTC_CNT_RST;
         lo1_r <= DTC_CNT_RST;
         hi1_r <= DTC_CNT_RST;
      end else begin
         lo0_r <= (wr_en & sel_t0lo) ? pwdata[7:0] : step0.lo;
         hi0_r <= (wr_en & sel_t0hi) ? pwdata[7:0] : hi0_calc;
         lo1_r <= (wr_en & sel_t1lo) ? pwdata[7:0] : step1.lo;
         hi1_r <= (wr_en & sel_t1hi) ? pwdata[7:0] : step1.hi;
      end
   end

   assign prdata        = prdata_r;
   assign pready        = pready_r;
   assign pslverr       = pslverr_r;
   assign overflow_flag = {flag1_r, flag0_r};

   // checks
   logic no_wr0;
   logic no_wr1;

   assign no_wr0 = ~(wr_en & (sel_t0lo | sel_t0hi));
   assign no_wr1 = ~(wr_en & (sel_t1lo | sel_t1hi));

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_stop_holds_cnt: assert property (
      (!run0_r && !t0_split && no_wr0) |=> $stable({hi0_r, lo0_r}))
      else $error("timer 0 count moved while stopped");

   a_timer_step: assert property (
      (tm[0].mode == DTC_MODE_16BIT && !tm[0].src && !tm[0].gate && run0_r && per_tick_r && no_wr0)
      |=> {hi0_r, lo0_r} == $past({hi0_r, lo0_r}) + 16'h0001)
      else $error("16-bit timer did not step by one");

   a_ovf_flag: assert property (
      (tm[0].mode == DTC_MODE_16BIT && go0 && {hi0_r, lo0_r} == 16'hFFFF && no_wr0)
      |=> flag0_r && {hi0_r, lo0_r} == 16'h0000)
      else $error("rollover did not set flag and clear count");

   a_reload_value: assert property (
      (tm[1].mode == DTC_MODE_RELOAD && !t0_split && go1 && lo1_r == DTC_BYTE_MAX && no_wr1)
      |=> lo1_r == $past(hi1_r) && hi1_r == $past(hi1_r) && flag1_r)
      else $error("auto-reload wrong");

   a_edge_only: assert property (
      (tm[0].src && !t0_split && !(ev_smp_r[0] && !sync2_r[0]) && no_wr0)
      |=> $stable({hi0_r, lo0_r}))
      else $error("counter moved without a falling edge");

   a_gate_blocks: assert property (
      (tm[1].gate && !sync2_r[3] && no_wr1) |=> $stable({hi1_r, lo1_r}))
      else $error("gated timer 1 counted with gate pin low");

   a_ack_clears: assert property (
      (irq_ack[1] && !set1) |=> !overflow_flag[1])
      else $error("service did not clear flag");

   a_t1_halt_hold: assert property (
      (tm[1].mode == DTC_MODE_SPLIT && no_wr1) [*3] |=> $stable({hi1_r, lo1_r}))
      else $error("timer 1 in halt mode changed count");

   a_presc_carry: assert property (
      (tm[0].mode == DTC_MODE_13BIT && go0 && lo0_r[4:0] == DTC_PRESC_MAX && no_wr0)
      |=> hi0_r == $past(hi0_r) + 8'h01 && lo0_r[4:0] == 5'h00)
      else $error("prescaler carry did not reach high byte");

   a_apb_ready: assert property (
      (acc && !pready) |=> pready ##1 !pready)
      else $error("apb ready not one cycle after access");

   c_t0_overflow:   cover property (set0 ##[1:4] irq_ack[0]);
   c_edge_count:    cover property (tm[0].src && go0);
   c_split_high:    cover property (t0_split && go0h && split_hi[8]);
   c_gated_resume:  cover property (tm[1].gate && !sync2_r[3] ##1 sync2_r[3] && go1);

endmodule

// file: rtl/dtc_pkg.sv
/*
 * dtc_pkg: register map, field layout, reset values and shared types
 * of the dual timer/counter.
 * Assumes a 32-bit APB master; every register is one aligned word.
 */
package dtc_pkg;

   // address decode
   localparam int          DTC_AW        = 12;
   localparam logic [11:0] DTC_CTRL_OFS  = 12'h000;
   localparam logic [11:0] DTC_MODE_OFS  = 12'h004;
   localparam logic [11:0] DTC_T0LO_OFS  = 12'h008;
   localparam logic [11:0] DTC_T0HI_OFS  = 12'h00C;
   localparam logic [11:0] DTC_T1LO_OFS  = 12'h010;
   localparam logic [11:0] DTC_T1HI_OFS  = 12'h014;

   // control word bit positions
   localparam int          DTC_RUN0_BIT  = 0;
   localparam int          DTC_FLAG0_BIT = 1;
   localparam int          DTC_RUN1_BIT  = 2;
   localparam int          DTC_FLAG1_BIT = 3;

   // mode word: timer 0 in bits 3:0, timer 1 in bits 7:4
   localparam int          DTC_TM0_LSB   = 0;
   localparam int          DTC_TM1_LSB   = 4;

   // reset values
   localparam logic [7:0]  DTC_CNT_RST   = 8'h00;
   localparam logic [7:0]  DTC_MODE_RST  = 8'h00;

   // peripheral cycle length in core clocks
   localparam int          DTC_PERIPH_DIV = 6;

   // counting limits
   localparam logic [4:0]  DTC_PRESC_MAX = 5'h1F;
   localparam logic [7:0]  DTC_BYTE_MAX  = 8'hFF;

   typedef enum logic [1:0] {
      DTC_MODE_13BIT  = 2'h0,
      DTC_MODE_16BIT  = 2'h1,
      DTC_MODE_RELOAD = 2'h2,
      DTC_MODE_SPLIT  = 2'h3
   } dtc_mode_t;

   typedef struct packed {
      logic      gate;
      logic      src;
      dtc_mode_t mode;
   } dtc_tmode_t;

   typedef struct packed {
      logic       ovf;
      logic [7:0] hi;
      logic [7:0] lo;
   } dtc_cnt_t;

endpackage

// file: verification/tb_dtc_top.sv
/*
 * tb_dtc_top: self-checking bench for the dual timer/counter.
 * Assumes dtc_pkg and dtc_top are compiled first; the bench itself acts as
 * APB master, pin source and interrupt controller on pclk.
 */
`timescale 1ns/1ps
module tb_dtc_top;
   import dtc_pkg::*;

   localparam int PD = 4;

   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        count_pin_0;
   logic        count_pin_1;
   logic        gate_pin_0;
   logic        gate_pin_1;
   logic [1:0]  irq_ack;
   logic        t0_irq_enabled;
   logic [1:0]  overflow_flag;
   logic        last_err;
   logic [31:0] rdv;
   int          error_cnt;
   int          checked;

   dtc_top #(.PERIPH_DIV(PD)) i_dtc_top (
      .pclk           (pclk),
      .presetn        (presetn),
      .psel           (psel),
      .penable        (penable),
      .pwrite         (pwrite),
      .paddr          (paddr),
      .pwdata         (pwdata),
      .prdata         (prdata),
      .pready         (pready),
      .pslverr        (pslverr),
      .count_pin_0    (count_pin_0),
      .count_pin_1    (count_pin_1),
      .gate_pin_0     (gate_pin_0),
      .gate_pin_1     (gate_pin_1),
      .irq_ack        (irq_ack),
      .t0_irq_enabled (t0_irq_enabled),
      .overflow_flag  (overflow_flag)
   );

   initial pclk = 1'b0;
   always #2 pclk = ~pclk;

   task automatic close_out;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         error_cnt++;
         $display("MISMATCH pready expected 1 seen 0");
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] v;
      xfer(1'b1, a, d, v);
   endtask

   task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] v;
      xfer(1'b0, a, 32'h0, v);
      chk(name, exp, v);
   endtask

   // commit-to-stop span of exactly n peripheral ticks
   task automatic window(input logic [11:0] a, input logic [31:0] d, input int n);
      wr(a, d);
      repeat (n * PD - 4) @(posedge pclk);
      wr(DTC_CTRL_OFS, 32'h0);
   endtask

   task automatic ack(input logic [1:0] m);
      @(posedge pclk);
      irq_ack <= m;
      @(posedge pclk);
      irq_ack <= 2'h0;
      @(posedge pclk);
   endtask

   task automatic s_reset;
      for (int i = 0; i < 6; i++) rchk("reset value", 12'(i * 4), 32'h0);
      chk("flags", 32'h0, {30'h0, overflow_flag});
   endtask

   task automatic s_mode1;
      wr(DTC_MODE_OFS, 32'h01);
      wr(DTC_T0LO_OFS, 32'hFE);
      wr(DTC_T0HI_OFS, 32'hFF);
      window(DTC_CTRL_OFS, 32'h1, 3);
      rchk("t0 low", DTC_T0LO_OFS, 32'h01);
      rchk("t0 high", DTC_T0HI_OFS, 32'h00);
      chk("flags", 32'h1, {30'h0, overflow_flag});
      t0_irq_enabled <= 1'b0;
      wr(DTC_CTRL_OFS, 32'h0);
      t0_irq_enabled <= 1'b1;
      @(posedge pclk);
      chk("flags", 32'h0, {30'h0, overflow_flag});
   endtask

   task automatic s_mode2;
      wr(DTC_MODE_OFS, 32'h20);
      wr(DTC_T1HI_OFS, 32'hF0);
      wr(DTC_T1LO_OFS, 32'hFE);
      window(DTC_CTRL_OFS, 32'h4, 3);
      rchk("t1 low", DTC_T1LO_OFS, 32'hF1);
      rchk("t1 high", DTC_T1HI_OFS, 32'hF0);
      chk("flags", 32'h2, {30'h0, overflow_flag});
      ack(2'h2);
      chk("flags", 32'h0, {30'h0, overflow_flag});
      wr(DTC_T1HI_OFS, 32'h80);
      wr(DTC_T1LO_OFS, 32'hFF);
      window(DTC_CTRL_OFS, 32'h4, 2);
      rchk("t1 low", DTC_T1LO_OFS, 32'h81);
      ack(2'h2);
   endtask

   task automatic s_mode0;
      wr(DTC_MODE_OFS, 32'h00);
      wr(DTC_T0LO_OFS, 32'h1E);
      wr(DTC_T0HI_OFS, 32'h05);
      window(DTC_CTRL_OFS, 32'h1, 3);
      xfer(1'b0, DTC_T0LO_OFS, 32'h0, rdv);
      chk("t0 prescaler", 32'h01, {27'h0, rdv[4:0]});
      rchk("t0 high", DTC_T0HI_OFS, 32'h06);
   endtask

   task automatic s_event;
      wr(DTC_MODE_OFS, 32'h55);
      wr(DTC_T0LO_OFS, 32'h00);
      wr(DTC_T0HI_OFS, 32'h00);
      wr(DTC_T1LO_OFS, 32'h00);
      wr(DTC_CTRL_OFS, 32'h5);
      // each level held three peripheral cycles
      for (int i = 0; i < 5; i++) begin
         repeat (3 * PD) @(posedge pclk);
         count_pin_0 <= 1'b1;
         count_pin_1 <= 1'b1;
         repeat (3 * PD) @(posedge pclk);
         count_pin_0 <= 1'b0;
         count_pin_1 <= 1'b0;
      end
      repeat (5 * PD) @(posedge pclk);
      wr(DTC_CTRL_OFS, 32'h0);
      rchk("t0 events", DTC_T0LO_OFS, 32'h05);
      rchk("t1 events", DTC_T1LO_OFS, 32'h05);
   endtask

   task automatic s_gate;
      wr(DTC_MODE_OFS, 32'h99);
      wr(DTC_T0LO_OFS, 32'h00);
      wr(DTC_T1LO_OFS, 32'h00);
      window(DTC_CTRL_OFS, 32'h5, 4);
      rchk("gated low", DTC_T0LO_OFS, 32'h00);
      rchk("t1 gated low", DTC_T1LO_OFS, 32'h00);
      gate_pin_0 <= 1'b1;
      gate_pin_1 <= 1'b1;
      repeat (4) @(posedge pclk);
      window(DTC_CTRL_OFS, 32'h5, 4);
      rchk("gated high", DTC_T0LO_OFS, 32'h04);
      rchk("t1 gated high", DTC_T1LO_OFS, 32'h04);
      gate_pin_0 <= 1'b0;
      gate_pin_1 <= 1'b0;
   endtask

   task automatic s_halt;
      wr(DTC_MODE_OFS, 32'h30);
      wr(DTC_T1LO_OFS, 32'h07);
      wr(DTC_T1HI_OFS, 32'h00);
      window(DTC_CTRL_OFS, 32'h4, 3);
      rchk("t1 halted", DTC_T1LO_OFS, 32'h07);
      wr(DTC_CTRL_OFS, 32'h4);
      // leaving the hold mode while running
      window(DTC_MODE_OFS, 32'h10, 3);
      rchk("t1 resumed", DTC_T1LO_OFS, 32'h0A);
   endtask

   task automatic s_split;
      wr(DTC_MODE_OFS, 32'h03);
      wr(DTC_T0LO_OFS, 32'h00);
      wr(DTC_T0HI_OFS, 32'hFE);
      window(DTC_CTRL_OFS, 32'h4, 2);
      rchk("split high", DTC_T0HI_OFS, 32'h00);
      rchk("split low", DTC_T0LO_OFS, 32'h00);
      chk("flags", 32'h2, {30'h0, overflow_flag});
      ack(2'h2);
      chk("flags", 32'h0, {30'h0, overflow_flag});
   endtask

   // reset in mid-run while both timers count
   task automatic s_rerun;
      wr(DTC_MODE_OFS, 32'h01);
      wr(DTC_CTRL_OFS, 32'h5);
      repeat (10) @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      s_reset;
   endtask

   task automatic s_unmapped;
      xfer(1'b0, 12'h100, 32'h0, rdv);
      chk("unmapped read data", 32'h0, rdv);
      chk("unmapped read error", 32'h1, {31'h0, last_err});
      wr(12'h100, 32'hFF);
      chk("unmapped write error", 32'h1, {31'h0, last_err});
   endtask

   initial begin
      presetn        = 1'b0;
      psel           = 1'b0;
      penable        = 1'b0;
      pwrite         = 1'b0;
      paddr          = 12'h000;
      pwdata         = 32'h0;
      count_pin_0    = 1'b0;
      count_pin_1    = 1'b0;
      gate_pin_0     = 1'b0;
      gate_pin_1     = 1'b0;
      irq_ack        = 2'h0;
      t0_irq_enabled = 1'b1;
      error_cnt      = 0;
      checked        = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      s_reset;
      s_mode1;
      s_mode2;
      s_mode0;
      s_event;
      s_gate;
      s_halt;
      s_split;
      s_rerun;
      s_unmapped;
      close_out;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      $display("MISMATCH watchdog expected done seen timeout");
      close_out;
   end

endmodule
